// File: pkg/ctg_pkg.sv
package ctg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rate and time base
  localparam int unsigned CORE_CLK_HZ   = 10_000_000;
  localparam int unsigned UNIT_TICK_MS  = 10;      // Unit integration period
  localparam int unsigned TICK_CYC      =
    CORE_CLK_HZ / 1000 * UNIT_TICK_MS;             // Core cycles per tick

  ////////////////////////////////////////////////////////////////////////////
  // Pixel timing, in core cycles within one pixel period
  localparam int unsigned PIX_DIV       = 16;      // Master clock divider
  localparam int unsigned PH_W          = 4;
  localparam logic [3:0]  PH_RESET_GATE = 4'h0;    // Charge reset pulse
  localparam logic [3:0]  PH_CLAMP      = 4'h4;    // Reference level clamp
  localparam logic [3:0]  PH_SAMPLE     = 4'ha;    // Converter sample
  localparam logic [3:0]  PH_CAPTURE    = 4'he;    // Converted word taken
  localparam logic [3:0]  PH_LAST       = 4'hf;
  localparam int unsigned DEF_PIXELS    = 64;
  localparam int unsigned DEF_LINES     = 64;
  localparam int unsigned CNT_W         = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the outside interfaces
  localparam int unsigned PIX_W         = 16;
  localparam int unsigned DIO_W         = 16;
  localparam int unsigned JMP_W         = 4;
  localparam int unsigned SER_W         = 16;
  localparam int unsigned MULT_W        = 8;
  localparam int unsigned TGT_W         = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the Avalon-MM slave
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_SERIAL    = 4'h8;
  localparam logic [3:0]  REG_INPUTS    = 4'hc;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int unsigned CTRL_OVR_BIT  = 0;       // Register sets multiple
  localparam int unsigned CTRL_HALT_BIT = 1;       // Stop after this frame
  localparam int unsigned CTRL_MULT_LSB = 8;
  localparam int unsigned STAT_INT_BIT  = 2;
  localparam int unsigned STAT_SER_BIT  = 3;
  localparam int unsigned STAT_FCNT_LSB = 16;
  localparam int unsigned INP_JMP_LSB   = 16;
  localparam int unsigned DIO_HALT_BIT  = 8;       // Remote stop input

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer states
  typedef enum logic [1:0] {
    CTG_IDLE   = 2'b00,
    CTG_INTEG  = 2'b01,
    CTG_VSHIFT = 2'b10,
    CTG_LINE   = 2'b11
  } ctg_state_t;

endpackage : ctg_pkg

// File: logic/ctg_sync2.sv
`timescale 1ns/100ps
module ctg_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Two stages; only the second stage is ever read by other logic
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule : ctg_sync2

// File: logic/ctg_ser_shift.sv
`timescale 1ns/100ps
module ctg_ser_shift
  import ctg_pkg::*;
(
  input  wire logic             ser_clk_i,
  input  wire logic             reset_i,
  input  wire logic             ser_data_i,
  input  wire logic             ser_load_i,
  output logic      [SER_W-1:0] ser_word_o
);

  logic [SER_W-1:0] shift_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Shift MSB first while load is low; the controller stops the serial
  // clock during load, so the word is stable when the core samples it
  always_ff @(posedge ser_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_ff <= '0;
    end else if (!ser_load_i) begin
      shift_ff <= {shift_ff[SER_W-2:0], ser_data_i}; // [R14]
    end
  end

  assign ser_word_o = shift_ff;

endmodule : ctg_ser_shift

// File: logic/ctg_timing_gen.sv
`timescale 1ns/100ps
//
// Contract
// [R1] Pixel timing is master clock divided by sixteen
// [R2] Integration built from 10 ms unit ticks
// [R3] Integration time is whole tick multiple, input selected
// [R4] Integrate output high exactly during integration
// [R5] Power-up or button reset loads default configuration
// [R6] Undriven inputs read zero; zeros give default mode
// [R7] Runs fully with no external control inputs
// [R8] Three-wire serial port driven by outside controller
// [R9] Four jumpers sampled as static mode levels; only jmp_s[1:0] affect the mode here
// [R10] Generate CCD clocks, strobes, grabber sync, sequencing
// [R11] Clamp strobe first, then converter sample strobe
// [R12] One 16-bit pixel channel plus three syncs
// [R13] Frame valid, line valid, pixel clock; data stable
// [R14] Serial word applied only when load asserted
module ctg_timing_gen
  import ctg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned PIXELS      = DEF_PIXELS,
  parameter int unsigned LINES       = DEF_LINES
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              ser_clk_i,
  input  wire logic              ser_data_i,
  input  wire logic              ser_load_i,
  input  wire logic [DIO_W-1:0]  dio_i,
  input  wire logic [JMP_W-1:0]  jmp_i,
  input  wire logic              board_reset_btn_i,
  input  wire logic [PIX_W-1:0]  adc_data_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   ccd_h1_o,
  output logic                   ccd_h2_o,
  output logic                   ccd_rg_o,
  output logic                   ccd_v1_o,
  output logic                   ccd_v2_o,
  output logic                   clamp_o,
  output logic                   adc_sample_o,
  output logic      [PIX_W-1:0]  pix_data_o,
  output logic                   frame_valid_o,
  output logic                   line_valid_o,
  output logic                   pixel_clk_o,
  output logic                   integrate_o,
  output logic                   unit_integration_tick_o
);

  localparam int unsigned SYNC_W = 2 + JMP_W + DIO_W + PIX_W;
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [CNT_W-1:0] PIX_LAST  = CNT_W'(PIXELS - 1);
  localparam logic [CNT_W-1:0] LINE_LAST = CNT_W'(LINES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Button, load, jumper, dio and converter pins pass two flip-flops before core-clock logic reads them
  logic [SYNC_W-1:0] sync_q;
  logic              btn_s;
  logic              load_s;
  logic [JMP_W-1:0]  jmp_s;
  logic [DIO_W-1:0]  dio_s;
  logic [PIX_W-1:0]  adc_s;
  logic [SER_W-1:0]  ser_word;

  ctg_sync2 #(
    .W          (SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .d_i        ({board_reset_btn_i, ser_load_i, jmp_i, dio_i, adc_data_i}),
    .q_o        (sync_q)
  );

  assign {btn_s, load_s, jmp_s, dio_s, adc_s} = sync_q;

  // Shift register lives on the serial clock of the outside controller
  ctg_ser_shift u_ser (
    .ser_clk_i  (ser_clk_i),
    .reset_i    (reset_i),
    .ser_data_i (ser_data_i),
    .ser_load_i (ser_load_i),
    .ser_word_o (ser_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  ctg_state_t        state_ff;
  ctg_state_t        nxt_state;
  logic [PH_W-1:0]   phase_ff;
  logic [23:0]       tick_cnt_ff;
  logic [TGT_W-1:0]  int_cnt_ff;
  logic [TGT_W-1:0]  nxt_int_cnt;
  logic [TGT_W-1:0]  int_target_ff;
  logic [CNT_W-1:0]  pix_cnt_ff;
  logic [CNT_W-1:0]  nxt_pix_cnt;
  logic [CNT_W-1:0]  line_cnt_ff;
  logic [CNT_W-1:0]  nxt_line_cnt;
  logic              vs_full_ff;
  logic [15:0]       frame_cnt_ff;
  logic [PIX_W-1:0]  pix_data_ff;
  logic              load_d_ff;
  logic              ser_applied_ff;
  logic [SER_W-1:0]  ser_word_ff;
  logic [31:0]       ctrl_ff;
  logic              ack_ff;
  logic [31:0]       rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of time base and pixel phase
  wire tick      = (tick_cnt_ff == TICK_LAST);
  wire ph_last   = (phase_ff == PH_LAST);
  wire line_end  = ph_last && (pix_cnt_ff == PIX_LAST);
  wire frame_end = line_end && (line_cnt_ff == LINE_LAST);
  wire load_rise = load_s && !load_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection; every source idles at zero, which is the default mode
  wire [MULT_W-1:0] mult_sel =
    ctrl_ff[CTRL_OVR_BIT] ? ctrl_ff[CTRL_MULT_LSB +: MULT_W] :
    ser_applied_ff        ? ser_word_ff[MULT_W-1:0] :
                            dio_s[MULT_W-1:0];         // [R6] [R7]
  // Jumpers scale the exposure by 1, 2, 4 or 8 ticks per step
  wire [TGT_W-1:0] tgt_sel =
    TGT_W'({1'b0, mult_sel} + 9'h001) << jmp_s[1:0];   // [R3] [R9]
  wire halt = ctrl_ff[CTRL_HALT_BIT] || dio_s[DIO_HALT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Free-running divider and unit tick
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_ff    <= '0;
      tick_cnt_ff <= '0;
    end else begin
      phase_ff    <= phase_ff + 4'h1;                  // [R1]
      tick_cnt_ff <= tick ? 24'h000000 : tick_cnt_ff + 24'h000001; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: wait tick, expose, then shift out the lines
  always_comb begin
    nxt_state    = state_ff;
    nxt_int_cnt  = int_cnt_ff;
    nxt_pix_cnt  = pix_cnt_ff;
    nxt_line_cnt = line_cnt_ff;
    unique case (state_ff)
      CTG_IDLE: begin
        nxt_int_cnt = '0;
        if (tick && !halt) begin
          nxt_state = CTG_INTEG;                       // [R10]
        end
      end
      CTG_INTEG: begin
        if (tick) begin
          if (int_cnt_ff == int_target_ff - 12'h001) begin
            nxt_state = CTG_VSHIFT;                    // [R3] [R4]
          end else begin
            nxt_int_cnt = int_cnt_ff + 12'h001;
          end
        end
      end
      CTG_VSHIFT: begin
        nxt_pix_cnt = '0;
        if (ph_last && vs_full_ff) begin
          nxt_state = CTG_LINE;
        end
      end
      CTG_LINE: begin
        if (ph_last) begin
          nxt_pix_cnt = pix_cnt_ff + 12'h001;
        end
        if (frame_end) begin
          nxt_state    = CTG_IDLE;
          nxt_line_cnt = '0;
        end else if (line_end) begin
          nxt_state    = CTG_VSHIFT;
          nxt_line_cnt = line_cnt_ff + 12'h001;
        end
      end
    endcase
  end

  // Button held: return to idle with default counters
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff    <= CTG_IDLE;
      int_cnt_ff  <= '0;
      pix_cnt_ff  <= '0;
      line_cnt_ff <= '0;
    end else if (btn_s) begin
      state_ff    <= CTG_IDLE;                         // [R5]
      int_cnt_ff  <= '0;
      pix_cnt_ff  <= '0;
      line_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      int_cnt_ff  <= nxt_int_cnt;
      pix_cnt_ff  <= nxt_pix_cnt;
      line_cnt_ff <= nxt_line_cnt;
    end
  end

  // Target frozen at exposure start so a mode change cannot cut it short
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_target_ff <= 12'h001;
    end else if (state_ff == CTG_IDLE) begin
      int_target_ff <= tgt_sel;                        // [R3]
    end
  end

  // First vertical shift after exposure may start mid-period
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      vs_full_ff <= 1'b0;
    end else if (state_ff != CTG_VSHIFT) begin
      vs_full_ff <= 1'b0;
    end else if (phase_ff == PH_RESET_GATE) begin
      vs_full_ff <= 1'b1;
    end
  end

  // Completed frames, shown in status
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_cnt_ff <= '0;
    end else if (btn_s) begin
      frame_cnt_ff <= '0;
    end else if (state_ff == CTG_LINE && frame_end) begin
      frame_cnt_ff <= frame_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel data: taken late in the period, so it is steady across the
  // rising pixel clock edge in mid-period
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pix_data_ff <= '0;
    end else if (state_ff == CTG_LINE && phase_ff == PH_CAPTURE) begin
      pix_data_ff <= adc_s;                            // [R12] [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial word is taken on the rising edge of the synchronised load
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      load_d_ff      <= 1'b0;
      ser_applied_ff <= 1'b0;
      ser_word_ff    <= '0;
    end else begin
      load_d_ff <= load_s;
      if (btn_s) begin
        ser_applied_ff <= 1'b0;                        // [R5]
        ser_word_ff    <= '0;
      end else if (load_rise) begin
        ser_applied_ff <= 1'b1;                        // [R8]
        ser_word_ff    <= ser_word;                    // [R14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state on every access
  wire        req      = avs_read_i || avs_write_i;
  wire        wr_take  = avs_write_i && ack_ff;
  wire [31:0] status_w = {frame_cnt_ff, 12'h000, ser_applied_ff,
                          integrate_o, state_ff};
  wire [31:0] inputs_w = {12'h000, jmp_s, dio_s};
  wire [31:0] rmux =
    (avs_address_i == REG_CTRL)   ? ctrl_ff :
    (avs_address_i == REG_STATUS) ? status_w :
    (avs_address_i == REG_SERIAL) ? {16'h0000, ser_word_ff} :
    (avs_address_i == REG_INPUTS) ? inputs_w : 32'h0000_0000;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= req && !ack_ff;
      if (avs_read_i && !ack_ff) begin
        rdata_ff <= rmux;
      end
    end
  end

  // Button restores the default configuration; unmapped writes drop
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_ff <= CTRL_RESET;
    end else if (btn_s) begin
      ctrl_ff <= CTRL_RESET;                           // [R5]
    end else if (wr_take && avs_address_i == REG_CTRL) begin
      ctrl_ff <= avs_writedata_i;
    end
  end

  assign avs_waitrequest_o = req && !ack_ff;
  assign avs_readdata_o    = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sensor clocks and analog strobes, all decoded from registered state
  wire in_line = (state_ff == CTG_LINE);
  wire in_vsh  = (state_ff == CTG_VSHIFT);

  assign ccd_h1_o     = !phase_ff[PH_W-1];             // [R10]
  assign ccd_h2_o     = phase_ff[PH_W-1];
  assign ccd_rg_o     = in_line && (phase_ff == PH_RESET_GATE);
  assign ccd_v1_o     = in_vsh && !phase_ff[PH_W-1];
  assign ccd_v2_o     = in_vsh && phase_ff[PH_W-1];
  assign clamp_o      = in_line && (phase_ff == PH_CLAMP);  // [R11]
  assign adc_sample_o = in_line && (phase_ff == PH_SAMPLE); // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Grabber side
  assign pix_data_o    = pix_data_ff;                  // [R12]
  assign pixel_clk_o   = phase_ff[PH_W-1];             // [R13]
  assign line_valid_o  = in_line;                      // [R13]
  assign frame_valid_o = in_line || in_vsh;            // [R13]
  assign integrate_o   = (state_ff == CTG_INTEG);      // [R4]
  assign unit_integration_tick_o = tick;               // [R2]

endmodule : ctg_timing_gen

// File: testbench/ctg_adc_model.sv
`timescale 1ns/100ps
module ctg_adc_model
  import ctg_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             adc_sample_i,
  output logic      [PIX_W-1:0] adc_data_o
);
  logic [PIX_W-1:0] word_ff;

  ////////////////////////////////////////////////////////////////////////////
  // A sample strobe starts a conversion; the word lands one clock later
  // and holds until the next strobe, as a real converter latch would
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_ff <= 16'h5a3c;
    end else if (adc_sample_i) begin
      word_ff <= word_ff + 16'h1357;
    end
  end
  assign adc_data_o = word_ff;
endmodule : ctg_adc_model

// File: testbench/ctg_timing_assertions.sv
`timescale 1ns/100ps
module ctg_timing_assertions
  import ctg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic             core_clk_i,
  input wire logic             reset_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic             avs_waitrequest_o,
  input wire logic             ccd_rg_o,
  input wire logic             ccd_h1_o,
  input wire logic             ccd_h2_o,
  input wire logic             ccd_v1_o,
  input wire logic             ccd_v2_o,
  input wire logic             clamp_o,
  input wire logic             adc_sample_o,
  input wire logic [PIX_W-1:0] pix_data_o,
  input wire logic             frame_valid_o,
  input wire logic             line_valid_o,
  input wire logic             pixel_clk_o,
  input wire logic             integrate_o,
  input wire logic             unit_integration_tick_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic [31:0] tick_cnt_ff;
  logic [31:0] integ_cnt_ff;
  logic        tick_seen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Counters too long for a repetition; first tick has no reference gap
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_ff  <= '0;
      integ_cnt_ff <= '0;
      tick_seen_ff <= 1'b0;
    end else begin
      tick_cnt_ff  <= unit_integration_tick_o ? '0 : tick_cnt_ff + 32'h1;
      integ_cnt_ff <= integrate_o ? integ_cnt_ff + 32'h1 : '0;
      tick_seen_ff <= tick_seen_ff | unit_integration_tick_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_tick_period: assert property (
    unit_integration_tick_o && tick_seen_ff |-> tick_cnt_ff == TICK_CYCLES-1)
    else $error("tick spacing wrong");
  chk_integ_whole: assert property (
    $fell(integrate_o) |-> integ_cnt_ff != 0 &&
      integ_cnt_ff % TICK_CYCLES == 0)
    else $error("integration not a tick multiple");
  chk_integ_on_tick: assert property (
    $rose(integrate_o) |->
      $past(unit_integration_tick_o) || $past(unit_integration_tick_o, 2))
    else $error("integration began off tick");
  chk_integ_no_frame: assert property (
    integrate_o |-> !frame_valid_o)
    else $error("readout during integration");
  chk_pixclk_period: assert property (
    $rose(pixel_clk_o) |-> ##16 $rose(pixel_clk_o))
    else $error("pixel clock period not 16");
  chk_pixclk_half: assert property (
    $rose(pixel_clk_o) |-> pixel_clk_o [*8] ##1 !pixel_clk_o)
    else $error("pixel clock high time wrong");
  chk_clamp_sample: assert property (
    clamp_o |-> ##6 adc_sample_o)
    else $error("sample did not follow clamp");
  chk_rg_clamp: assert property (
    ccd_rg_o |-> ##4 clamp_o)
    else $error("clamp did not follow reset gate");
  chk_h_opposed: assert property (
    ccd_h1_o != ccd_h2_o)
    else $error("horizontal clocks not opposed");
  chk_v_shift_only: assert property (
    (ccd_v1_o || ccd_v2_o) |-> frame_valid_o && !line_valid_o)
    else $error("vertical clock outside shift");
  chk_line_frame: assert property (
    line_valid_o |-> frame_valid_o)
    else $error("line valid outside frame");
  chk_pix_stable: assert property (
    $rose(pixel_clk_o) |-> $stable(pix_data_o) [*4])
    else $error("pixel word moved at pixel clock edge");
  chk_wait_once: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");

  cover property ($fell(frame_valid_o));
  cover property ($fell(integrate_o));
  cover property (avs_write_i && !avs_waitrequest_o);
endmodule : ctg_timing_assertions

bind ctg_timing_gen ctg_timing_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .ccd_rg_o(ccd_rg_o), .clamp_o(clamp_o), .adc_sample_o(adc_sample_o),
  .ccd_h1_o(ccd_h1_o), .ccd_h2_o(ccd_h2_o), .ccd_v1_o(ccd_v1_o),
  .ccd_v2_o(ccd_v2_o),
  .pix_data_o(pix_data_o), .frame_valid_o(frame_valid_o),
  .line_valid_o(line_valid_o), .pixel_clk_o(pixel_clk_o),
  .integrate_o(integrate_o),
  .unit_integration_tick_o(unit_integration_tick_o));

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import ctg_pkg::*;
  localparam int unsigned TK = 50;
  logic core_clk_i, reset_i, ser_clk_i, ser_data_i, ser_load_i, btn_i;
  logic [DIO_W-1:0] dio_i;
  logic [JMP_W-1:0] jmp_i;
  logic [PIX_W-1:0] adc_data_i, pix_data_o;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic avs_read_i, avs_write_i, avs_waitrequest_o, rg_o, clamp_o, smp_o;
  logic frame_valid_o, line_valid_o, pixel_clk_o, integrate_o, tick_o;
  int err_total, n_compared;

  ctg_timing_gen #(.TICK_CYCLES(TK), .PIXELS(4), .LINES(4)) dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i), .ser_load_i(ser_load_i), .dio_i(dio_i),
    .jmp_i(jmp_i), .board_reset_btn_i(btn_i), .adc_data_i(adc_data_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ccd_h1_o(), .ccd_h2_o(), .ccd_rg_o(rg_o), .ccd_v1_o(), .ccd_v2_o(),
    .clamp_o(clamp_o), .adc_sample_o(smp_o), .pix_data_o(pix_data_o),
    .frame_valid_o(frame_valid_o), .line_valid_o(line_valid_o),
    .pixel_clk_o(pixel_clk_o), .integrate_o(integrate_o),
    .unit_integration_tick_o(tick_o));
  ctg_adc_model u_adc (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .adc_sample_i(smp_o), .adc_data_o(adc_data_i));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared checking and closing
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : chk
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  function automatic logic pick(int s);
    return (s == 0) ? frame_valid_o : integrate_o;
  endfunction : pick
  // Every wait is bounded so a stuck sequencer ends the run
  task automatic wait_lvl(int s, logic v);
    int n;
    n = 0;
    while (pick(s) !== v) begin
      @(posedge core_clk_i);
      if (++n > 3000) begin
        chk("wait bound", 32'h1, 32'h0);
        stop_test();
      end
    end
  endtask : wait_lvl

  ////////////////////////////////////////////////////////////////////////////
  // Avalon master: hold the request until waitrequest is seen low
  task automatic av(logic wr, logic [3:0] a, logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      if (++n > 20) chk("waitrequest bound", 32'h1, 32'h0);
      if (n > 20) stop_test();
      @(posedge core_clk_i);
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : av
  task automatic rd(string nm, logic [3:0] a, logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask : rd
  // Settings are latched in idle, so skip one whole frame before timing
  task automatic integ(string nm, int exp);
    int n;
    wait_lvl(0, 1'b1);
    wait_lvl(0, 1'b0);
    wait_lvl(1, 1'b1);
    n = 0;
    while (integrate_o === 1'b1 && n < 3000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(nm, n, exp);
    if (n >= 3000) stop_test();
  endtask : integ

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults();
    rd("ctrl reset", REG_CTRL, CTRL_RESET);
    rd("inputs idle", REG_INPUTS, 32'h0);
    rd("unmapped", 4'h2, 32'h0);
    integ("default integ", TK);
  endtask : t_defaults
  task automatic t_frame();
    int lines, clamps, n;
    logic prev;
    lines = 0;
    clamps = 0;
    n = 0;
    prev = 1'b0;
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    while (frame_valid_o === 1'b1 && n < 3000) begin
      lines += (line_valid_o === 1'b1 && !prev);
      clamps += (clamp_o === 1'b1);
      prev = (line_valid_o === 1'b1);
      n++;
      @(posedge core_clk_i);
    end
    chk("lines", lines, 4);
    chk("clamps", clamps, 16);
    chk("last pixel", pix_data_o, adc_data_i);
    if (n >= 3000) stop_test();
  endtask : t_frame
  task automatic t_dio();
    dio_i <= 16'h0002;
    jmp_i <= 4'h1;
    repeat (4) @(posedge core_clk_i);
    rd("inputs", REG_INPUTS, 32'h0001_0002);
    integ("dio integ", 6 * TK);
  endtask : t_dio
  task automatic t_serial(logic [15:0] w);
    jmp_i <= 4'h0;
    #7;
    for (int i = 15; i >= 0; i--) begin
      ser_data_i = w[i];
      #15 ser_clk_i = 1'b1;
      #15 ser_clk_i = 1'b0;
    end
    ser_data_i = ~ser_data_i;
    rd("serial before load", REG_SERIAL, 32'h0);
    ser_load_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    ser_load_i <= 1'b0;
    rd("serial word", REG_SERIAL, {16'h0, w});
    integ("serial integ", (w[7:0] + 1) * TK);
  endtask : t_serial
  task automatic t_override();
    logic [31:0] q;
    av(1'b1, REG_CTRL, 32'h0000_0101, q);
    rd("ctrl back", REG_CTRL, 32'h0000_0101);
    integ("override integ", 2 * TK);
  endtask : t_override
  // Halt holds the sequencer idle; no exposure may start meanwhile
  task automatic t_halt();
    logic [31:0] q;
    int n;
    av(1'b1, REG_CTRL, 32'h0000_0002, q);
    wait_lvl(0, 1'b0);
    n = 0;
    repeat (4 * TK) begin
      n += (integrate_o === 1'b1);
      @(posedge core_clk_i);
    end
    chk("halted integ", n, 0);
    av(1'b1, REG_CTRL, 32'h0, q);
  endtask : t_halt
  task automatic t_button();
    wait_lvl(0, 1'b1);
    btn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    btn_i <= 1'b0;
    rd("status after button", REG_STATUS, 32'h0);
    rd("ctrl after button", REG_CTRL, 32'h0);
    rd("serial after button", REG_SERIAL, 32'h0);
  endtask : t_button

  initial begin
    {ser_clk_i, ser_data_i, ser_load_i, btn_i} = 4'h0;
    {dio_i, jmp_i, avs_address_i, avs_writedata_i} = '0;
    {avs_read_i, avs_write_i} = 2'h0;
    err_total = 0;
    n_compared = 0;
    reset_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_defaults();
    t_frame();
    t_dio();
    t_serial(16'h0004);
    t_override();
    t_halt();
    t_button();
    stop_test();
  end
endmodule : tb
